// *** io_ports_map.svh ***
// Offsets, field positions, reset values and port constants of the configurable I/O ports
`ifndef IO_PORTS_MAP_SVH
`define IO_PORTS_MAP_SVH

`define PORT_COUNT 7
`define PORT_IDX_W 3
`define REG_ADDR_W 6
`define PORT_FIELD_MSB 5
`define PORT_FIELD_LSB 3
`define REG_FIELD_MSB 2
`define REG_FIELD_LSB 0

`define PORT_NARROW 3'h3
`define PORT_ISP 3'h4
`define PORT_DATA_LO 3'h5
`define PORT_DATA_HI 3'h6

`define OFS_DATA_IN 3'h0
`define OFS_DATA_OUT 3'h1
`define OFS_DIRECTION 3'h2
`define OFS_CONTROL 3'h3
`define OFS_CELL_OUT 3'h4

`define PCR_RESET 8'h00
`define RDATA_IDLE 8'h00
`define MASK_FULL 8'hff
`define MASK_NARROW 8'h0f
`define MASK_NONE 8'h00
`define MASK_BURST_ADDR 8'hf0

`define CTL_PORTS 7'h70
`define INPUT_CAPABLE_PORTS 7'h2f
`define GLA_OUT_PORTS 7'h07

`endif

// *** io_ports_pkg.sv ***
// Types shared by the configurable I/O ports
`include "io_ports_map.svh"

package io_ports_pkg;

   typedef logic [`PORT_COUNT-1:0][7:0] port_bank_t;

   // Fixed configuration, set when the device is programmed
   typedef struct packed {
      port_bank_t logic_in;
      port_bank_t logic_out;
      port_bank_t addr_in;
      port_bank_t decode_use;
      port_bank_t addr_latch;
      logic nonmux;
      logic burst;
      logic reset_pattern_en;
      logic [15:0] reset_pattern;
      logic isp_en;
   } cfg_s;

   typedef struct packed {
      port_bank_t data_out;
      port_bank_t dir;
      port_bank_t ctl;
      port_bank_t pin_out;
      port_bank_t pin_oe_n;
      port_bank_t hi_addr;
      port_bank_t array_in;
      logic [15:0] laddr;
      logic [15:0] bus_wdata;
      logic [7:0] isp_in;
      logic [7:0] rdata;
   } state_s;

endpackage

// *** port_output_select.sv ***
// Output selector and driver enable for the pins of one port
`timescale 1ns/100ps

module port_output_select (
   input wire logic [7:0] dout,
   input wire logic [7:0] dir,
   input wire logic [7:0] ctl,
   input wire logic [7:0] laddr,
   input wire logic [7:0] laddr_mask,
   input wire logic [7:0] gla_out,
   input wire logic [7:0] gla_oe,
   input wire logic [7:0] logic_out,
   input wire logic [7:0] logic_in,
   input wire logic [7:0] width_mask,
   input wire logic data_sel,
   input wire logic [7:0] data_val,
   input wire logic data_drive,
   input wire logic isp_sel,
   input wire logic [7:0] isp_out,
   input wire logic [7:0] isp_oe,
   output logic [7:0] out,
   output logic [7:0] oe
);

   always_comb begin
      out = 8'h00;
      oe = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (data_sel) begin
            // General I/O is cut off while the port carries the host data bus
            out[i] = data_val[i];
            oe[i] = data_drive;
         end else if (isp_sel) begin
            out[i] = isp_out[i];
            oe[i] = isp_oe[i];
         end else if (ctl[i]) begin
            // Unused address nibbles stay floating rather than drive stale bits
            out[i] = laddr[i] & laddr_mask[i];
            oe[i] = (dir[i] | gla_oe[i]) & laddr_mask[i];
         end else if (logic_out[i]) begin
            out[i] = gla_out[i];
            oe[i] = gla_oe[i];
         end else begin
            out[i] = dout[i];
            // A logic input pin ignores its direction bit; it drives only when its logic enable term is set
            oe[i] = (dir[i] & ~logic_in[i]) | gla_oe[i];
         end
         out[i] = out[i] & width_mask[i];
         oe[i] = oe[i] & width_mask[i];
      end
   end

endmodule

// *** configurable_io_ports.sv ***
// Seven configurable I/O ports with data and direction registers, control registers on ports 4 to 6 only
`timescale 1ns/100ps
`include "io_ports_map.svh"

// What this block does
// - Seven ports, eight pins, one port four
// - Every pin configured on its own
// - Output picks data-out, latched address, logic output
// - Readback drives exactly one source at once
// - Fixed modes from configuration, others by writes
// - Control bit zero means host-mapped I/O
// - Direction one drives data-out, zero reads pin
// - First four ports lack control, default I/O
// - Logic input pins must not get direction one
// - Address out when enable term or dir and control
// - Address nibbles mapped onto the address-out ports
// - Upper address pins feed arrays, optionally latched
// - Decode-equation inputs count as address inputs
// - Data ports carry host bus, I/O disabled
// - One port offers in-system programming mode
// - Reset pattern driven in reset, no cycle
// - Configuration registers power up as zero
// - Data ports float unless host reads or pattern drives
module configurable_io_ports (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [`REG_ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire io_ports_pkg::cfg_s cfg,
   input wire io_ports_pkg::port_bank_t pin_in,
   output io_ports_pkg::port_bank_t pin_out,
   output io_ports_pkg::port_bank_t pin_oe_n,
   input wire io_ports_pkg::port_bank_t gla_out,
   input wire io_ports_pkg::port_bank_t gla_oe,
   output io_ports_pkg::port_bank_t array_in,
   input wire logic address_latch_strobe,
   input wire logic [15:0] host_addr,
   input wire logic host_cycle,
   input wire logic host_rd_active,
   input wire logic host_reset_active,
   input wire logic [15:0] bus_rdata,
   output logic [15:0] bus_wdata,
   input wire logic [7:0] isp_out,
   input wire logic [7:0] isp_oe,
   output logic [7:0] isp_in
);

   localparam io_ports_pkg::state_s ST_RESET = '{pin_oe_n: '1, default: '0};

   io_ports_pkg::state_s st_reg;
   io_ports_pkg::state_s st_next;
   io_ports_pkg::port_bank_t sel_out;
   io_ports_pkg::port_bank_t sel_oe;
   logic pattern_drive;

   function automatic logic [7:0] port_mask(input logic [`PORT_IDX_W-1:0] p);
      if (p == `PORT_NARROW) begin
         port_mask = `MASK_NARROW;
      end else begin
         port_mask = `MASK_FULL;
      end
   endfunction

   function automatic logic port_has(input logic [`PORT_COUNT-1:0] set,
                                     input logic [`PORT_IDX_W-1:0] p);
      port_has = set[p];
   endfunction

   // Pattern only while the host holds reset and no bus cycle is running
   assign pattern_drive = cfg.reset_pattern_en & host_reset_active & ~host_cycle;

   for (genvar g = 0; g < `PORT_COUNT; g++) begin : g_port
      localparam logic [`PORT_IDX_W-1:0] PIDX = `PORT_IDX_W'(g);
      logic [7:0] lbyte;
      logic [7:0] lmask;
      logic [7:0] dval;
      logic dsel;
      logic [7:0] lout;
      always_comb begin
         lbyte = st_reg.laddr[7:0];
         lmask = `MASK_NONE;
         if (PIDX == `PORT_DATA_HI) begin
            lbyte = st_reg.laddr[15:8];
            lmask = `MASK_FULL;
         end else if (port_has(`CTL_PORTS, PIDX)) begin
            lmask = cfg.burst ? `MASK_BURST_ADDR : `MASK_FULL;
         end
         dsel = cfg.nonmux & (PIDX == `PORT_DATA_LO || PIDX == `PORT_DATA_HI);
         dval = (PIDX == `PORT_DATA_HI) ? bus_rdata[15:8] : bus_rdata[7:0];
         if (pattern_drive) begin
            dval = (PIDX == `PORT_DATA_HI) ? cfg.reset_pattern[15:8]
                                           : cfg.reset_pattern[7:0];
         end
         lout = port_has(`GLA_OUT_PORTS, PIDX) ? cfg.logic_out[g] : `MASK_NONE;
      end
      port_output_select u_sel (
         .dout(st_reg.data_out[g]),
         .dir(st_reg.dir[g]),
         .ctl(st_reg.ctl[g]),
         .laddr(lbyte),
         .laddr_mask(lmask),
         .gla_out(gla_out[g]),
         .gla_oe(gla_oe[g]),
         .logic_out(lout),
         .logic_in(cfg.logic_in[g]),
         .width_mask(port_mask(PIDX)),
         .data_sel(dsel),
         .data_val(dval),
         .data_drive(pattern_drive | host_rd_active),
         .isp_sel(cfg.isp_en & (PIDX == `PORT_ISP)),
         .isp_out(isp_out),
         .isp_oe(isp_oe),
         .out(sel_out[g]),
         .oe(sel_oe[g])
      );
   end

   always_comb begin
      logic [`PORT_IDX_W-1:0] p;
      logic [2:0] r;
      logic [7:0] cap;
      p = addr[`PORT_FIELD_MSB:`PORT_FIELD_LSB];
      r = addr[`REG_FIELD_MSB:`REG_FIELD_LSB];
      cap = `MASK_NONE;
      st_next = st_reg;
      // Host writes reach only the run-time registers; fixed modes live in cfg
      if (wr && p < `PORT_IDX_W'(`PORT_COUNT)) begin
         unique case (r)
            `OFS_DATA_OUT: st_next.data_out[p] = wdata & port_mask(p);
            `OFS_DIRECTION: st_next.dir[p] = wdata & port_mask(p);
            `OFS_CONTROL: begin
               if (port_has(`CTL_PORTS, p)) begin
                  st_next.ctl[p] = wdata;
               end
            end
            default: begin
            end
         endcase
      end
      // Readback: one source per read, zero outside the answer cycle
      st_next.rdata = `RDATA_IDLE;
      if (rd && p < `PORT_IDX_W'(`PORT_COUNT)) begin
         unique case (r)
            `OFS_DATA_IN: st_next.rdata = pin_in[p] & port_mask(p);
            `OFS_DATA_OUT: st_next.rdata = st_reg.data_out[p];
            `OFS_DIRECTION: st_next.rdata = st_reg.dir[p];
            `OFS_CONTROL: st_next.rdata = st_reg.ctl[p];
            `OFS_CELL_OUT: st_next.rdata = gla_out[p] & port_mask(p);
            default: st_next.rdata = `RDATA_IDLE;
         endcase
      end
      st_next.pin_out = sel_out;
      st_next.pin_oe_n = ~sel_oe;
      if (address_latch_strobe) begin
         st_next.laddr = host_addr;
      end
      for (int i = 0; i < `PORT_COUNT; i++) begin
         cap = `MASK_NONE;
         if (port_has(`INPUT_CAPABLE_PORTS, `PORT_IDX_W'(i))) begin
            cap = cfg.addr_in[i] | cfg.decode_use[i];
         end
         if (address_latch_strobe) begin
            st_next.hi_addr[i] = pin_in[i] & cap;
         end
         if (port_has(`INPUT_CAPABLE_PORTS, `PORT_IDX_W'(i))) begin
            cap = cap | cfg.logic_in[i];
         end
         for (int b = 0; b < 8; b++) begin
            st_next.array_in[i][b] = cap[b] & (cfg.addr_latch[i][b] ? st_reg.hi_addr[i][b]
                                                                    : pin_in[i][b]);
         end
         st_next.array_in[i] = st_next.array_in[i] & port_mask(`PORT_IDX_W'(i));
      end
      st_next.bus_wdata = cfg.nonmux ? {pin_in[`PORT_DATA_HI], pin_in[`PORT_DATA_LO]}
                                     : 16'h0000;
      st_next.isp_in = cfg.isp_en ? pin_in[`PORT_ISP] : 8'h00;
   end

   // All registers clear at power-up except pin_oe_n, which sets, so every pin starts as an input
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;
   assign pin_out = st_reg.pin_out;
   assign pin_oe_n = st_reg.pin_oe_n;
   assign array_in = st_reg.array_in;
   assign bus_wdata = st_reg.bus_wdata;
   assign isp_in = st_reg.isp_in;

endmodule

// *** pin_model.sv ***
// Outside world seen by the port pins
`timescale 1ns/100ps
module pin_model (
   input wire io_ports_pkg::port_bank_t pin_out,
   input wire io_ports_pkg::port_bank_t pin_oe_n,
   input wire io_ports_pkg::port_bank_t ext_drive,
   output io_ports_pkg::port_bank_t pin_in
);
   // A pin follows its own driver when enabled, else the outside source
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
endmodule

// *** io_checker.sv ***
// Assertions on the ports of the configurable I/O ports
`timescale 1ns/100ps
module io_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire io_ports_pkg::cfg_s cfg,
   input wire io_ports_pkg::port_bank_t pin_in,
   input wire io_ports_pkg::port_bank_t pin_out,
   input wire io_ports_pkg::port_bank_t pin_oe_n,
   input wire logic host_cycle,
   input wire logic host_rd_active,
   input wire logic host_reset_active,
   input wire logic [15:0] bus_rdata,
   input wire logic [15:0] bus_wdata,
   input wire logic [7:0] isp_in
);
   logic [1:0] live_reg;
   // Sampled history reaches back into reset, so checks wait two edges
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         live_reg <= 2'h0;
      end else begin
         live_reg <= {live_reg[0], 1'b1};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst || !live_reg[1]);
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside its cycle");
   a_narrow_port: assert property (pin_oe_n[3][7:4] == 4'hf)
      else $error("missing pins driven");
   a_data_float: assert property (cfg.nonmux && !$past(host_rd_active)
      && !$past(host_reset_active) |-> pin_oe_n[6:5] == 16'hffff)
      else $error("data port driven while idle");
   a_data_drive: assert property (cfg.nonmux && $past(host_rd_active)
      && !$past(host_reset_active) |-> pin_out[6:5] == $past(bus_rdata) && pin_oe_n[6:5] == 0)
      else $error("data port not carrying read data");
   a_bus_capture: assert property
      (bus_wdata == (cfg.nonmux ? $past({pin_in[6], pin_in[5]}) : 16'h0000))
      else $error("bus write data wrong");
   a_reset_pattern: assert property (cfg.nonmux && cfg.reset_pattern_en
      && $past(host_reset_active) && !$past(host_cycle) |-> pin_out[6:5] == cfg.reset_pattern)
      else $error("reset pattern not driven");
   a_isp_input: assert property (isp_in == (cfg.isp_en ? $past(pin_in[4]) : 8'h00))
      else $error("programming input wrong");
   a_ctl_refused: assert property (rd && addr[2:0] == 3'h3 && addr[5:3] < 3'h4
      |=> rdata == 8'h00)
      else $error("control read on port without control");
   a_write_read: assert property (wr && addr[5:3] == 3'h4 && addr[2:0] != 0
      && addr[2:0] < 3'h4 ##1 rd && $stable(addr) |=> rdata == $past(wdata, 2))
      else $error("read after write lost value");
   c_write_read: cover property (wr ##1 rd);
   c_data_read: cover property (cfg.nonmux && host_rd_active);
   c_pattern: cover property (cfg.reset_pattern_en && host_reset_active && !host_cycle);
endmodule
bind configurable_io_ports io_checker u_chk (.clk(clk), .nrst(nrst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cfg(cfg), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .host_cycle(host_cycle),
   .host_rd_active(host_rd_active), .host_reset_active(host_reset_active),
   .bus_rdata(bus_rdata), .bus_wdata(bus_wdata), .isp_in(isp_in));

// *** tb.sv ***
// Self-checking bench of the configurable I/O ports
`timescale 1ns/100ps
`include "io_ports_map.svh"
module tb;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, strobe = 0, cyc = 0, rd_act = 0, rst_act = 0;
   logic [5:0] addr = 0;
   logic [7:0] wdata = 0, rdata, isp_out = 0, isp_oe = 0, isp_in;
   logic [15:0] host_addr = 0, bus_rdata = 0, bus_wdata;
   io_ports_pkg::cfg_s cfg = '0;
   io_ports_pkg::port_bank_t pin_in, pin_out, pin_oe_n, array_in;
   io_ports_pkg::port_bank_t gla_out = '0, gla_oe = '0, ext = '0;
   logic [31:0] seed = 32'h43fd_0ece;
   int n_mismatch = 0, n_compared = 0;
   initial forever #25 clk = ~clk;
   configurable_io_ports u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .cfg(cfg), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .gla_out(gla_out), .gla_oe(gla_oe), .array_in(array_in),
      .address_latch_strobe(strobe), .host_addr(host_addr), .host_cycle(cyc),
      .host_rd_active(rd_act), .host_reset_active(rst_act), .bus_rdata(bus_rdata),
      .bus_wdata(bus_wdata), .isp_out(isp_out), .isp_oe(isp_oe), .isp_in(isp_in));
   pin_model u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drive(ext), .pin_in(pin_in));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected readback of a register that was just written
   function automatic logic [7:0] exp_readback(input logic [2:0] p, input logic [2:0] o,
                                               input logic [7:0] d);
      if (o == `OFS_CONTROL) begin
         return p > `PORT_NARROW ? d : 8'h00;
      end
      return p == `PORT_NARROW ? d & `MASK_NARROW : d;
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Strobes stay up until the next call, so transfers can run back to back
   task automatic wr_reg(input logic [2:0] p, input logic [2:0] o, input logic [7:0] d);
      addr <= {p, o};
      wdata <= d;
      wr <= 1;
      rd <= 0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [2:0] p, input logic [2:0] o, output logic [7:0] d);
      addr <= {p, o};
      wr <= 0;
      rd <= 1;
      @(posedge clk);
      #1 d = rdata;
   endtask
   task automatic idle(input int n);
      wr <= 0;
      rd <= 0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Configuration is static, so it only changes under reset
   task automatic restart(input io_ports_pkg::cfg_s c);
      wr <= 0;
      rd <= 0;
      nrst <= 0;
      cfg <= c;
      repeat (2) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
   endtask
   initial begin
      #3000000;
      n_mismatch++;
      test_done();
   end
   initial begin
      logic [7:0] d, m, v;
      logic [2:0] p, o;
      io_ports_pkg::cfg_s c;
      io_ports_pkg::port_bank_t e;
      repeat (16) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      for (int i = 0; i < 21; i++) begin
         rd_reg(3'(i / 3), 3'(i % 3 + 1), v);
         chk("reset value", v, 8'h00);
      end
      for (int i = 0; i < 40; i++) begin
         p = 3'(xs() % 7);
         o = 3'(xs() % 3 + 1);
         d = 8'(xs());
         wr_reg(p, o, d);
         rd_reg(p, o, v);
         chk("readback", v, exp_readback(p, o, d));
      end
      rd_reg(3'h7, 3'h1, v);
      chk("unmapped port", v, 8'h00);
      rd_reg(3'h0, 3'h5, v);
      chk("unmapped offset", v, 8'h00);
      restart('0);
      d = 8'(xs());
      m = 8'(xs());
      ext <= 56'({xs(), xs()});
      wr_reg(3'h4, `OFS_DATA_OUT, d);
      wr_reg(3'h4, `OFS_DIRECTION, m);
      idle(2);
      chk("drive enable", pin_oe_n[4], ~m);
      chk("drive value", pin_out[4] & m, d & m);
      rd_reg(3'h4, `OFS_DATA_IN, v);
      chk("data in", v, (d & m) | (ext[4] & ~m));
      for (int b = 0; b < 2; b++) begin
         c = '0;
         c.burst = b[0];
         restart(c);
         host_addr <= 16'(xs());
         strobe <= 1;
         wr_reg(3'h4, `OFS_CONTROL, 8'hff);
         strobe <= 0;
         wr_reg(3'h4, `OFS_DIRECTION, 8'hff);
         wr_reg(3'h6, `OFS_CONTROL, 8'hff);
         wr_reg(3'h6, `OFS_DIRECTION, 8'hff);
         idle(3);
         chk("address E", {pin_out[4][7:4], b ? pin_oe_n[4][3:0] : pin_out[4][3:0]},
            {host_addr[7:4], b ? 4'hf : host_addr[3:0]});
         chk("address G", pin_out[6], host_addr[15:8]);
      end
      c = '0;
      c.logic_out[0] = 8'hff;
      c.logic_in[1] = 8'hff;
      restart(c);
      gla_out <= 56'({xs(), xs()});
      gla_oe <= 56'({xs(), xs()});
      wr_reg(3'h1, `OFS_DIRECTION, 8'hff);
      idle(3);
      chk("logic out", pin_out[0] & gla_oe[0], gla_out[0] & gla_oe[0]);
      chk("logic enable", pin_oe_n[0], ~gla_oe[0]);
      chk("logic input enable", pin_oe_n[1], ~gla_oe[1]);
      chk("array input", array_in[1], ext[1] & ~gla_oe[1]);
      chk("array unused", array_in[4], 8'h00);
      // Latched high address must hold after the pins move on
      c = '0;
      c.addr_in[5] = 8'hff;
      c.addr_latch[5] = 8'hff;
      c.decode_use[2] = 8'hff;
      gla_oe <= '0;
      restart(c);
      e = 56'({xs(), xs()});
      ext <= e;
      strobe <= 1;
      idle(1);
      strobe <= 0;
      ext <= 56'({xs(), xs()});
      idle(3);
      chk("latched address in", array_in[5], e[5]);
      chk("decode input", array_in[2], ext[2]);
      c = '0;
      c.nonmux = 1;
      c.reset_pattern_en = 1;
      c.isp_en = 1;
      c.reset_pattern = 16'(xs());
      restart(c);
      for (int i = 0; i < 300; i++) begin
         {cyc, rd_act, rst_act} <= 3'(xs());
         bus_rdata <= 16'(xs());
         ext <= 56'({xs(), xs()});
         isp_out <= 8'(xs());
         isp_oe <= 8'(xs());
         @(posedge clk);
      end
      cyc <= 0;
      rst_act <= 1;
      rd_act <= 0;
      idle(2);
      chk("pattern low", pin_out[5], c.reset_pattern[7:0]);
      chk("pattern high", pin_out[6], c.reset_pattern[15:8]);
      test_done();
   end
endmodule
